// File: logic/wib_map.vh
`ifndef WIB_MAP_VH
`define WIB_MAP_VH

// Register byte addresses on the APB slave.
// The holding register keeps its odd index, so its word sits at four times that index.
`define WIB_IDX_HOLD 8'hf9
`define WIB_ADDR_HOLD 10'h3e4
`define WIB_ADDR_CTRL 10'h0f0
`define WIB_ADDR_STAT 10'h0f4
`define WIB_ADDR_PTR 10'h0e0
`define WIB_ADDR_SFRP 10'h0e4
`define WIB_ADDR_ACC 10'h0e8
`define WIB_ADDR_CMD 10'h0ec

// Control register fields.
`define WIB_CTRL_WIDE 0
`define WIB_CTRL_STRETCH 1
`define WIB_CTRL_PHDIS 2
`define WIB_CTRL_X2 3

// Command register fields.
`define WIB_CMD_GO 0
`define WIB_CMD_READ 1
`define WIB_CMD_SHORT 2

// Reset values.
`define WIB_HOLD_RST 8'h00
`define WIB_CTRL_RST 4'h0

// Timing in CPU clock periods; the OSC values are oscillator periods per CPU period.
`define WIB_CYCLE_CPU 4'h6
`define WIB_STROBE_CPU 4'h3
`define WIB_STROBE_LONG 4'hf
`define WIB_OSC_STD 4'hc
`define WIB_OSC_X2 4'h6

`endif

// File: logic/wib_cpu_clk.v
`include "wib_map.vh"
`default_nettype none

// Produces the one-cycle CPU-period enable from the oscillator clock.
module wib_cpu_clk (
	// Clock and reset
	input wire i_mclk,
	input wire i_rst_n,
	// Mode
	input wire i_double_speed_mode,
	// Enable
	output wire o_cpu_en
);
	reg [3:0] cnt_reg;
	wire [3:0] last;

	// One CPU period is 12 oscillator periods in standard mode, 6 in double speed.
	assign last = i_double_speed_mode ? 4'h5 : 4'hb;
	assign o_cpu_en = (cnt_reg == last);

	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			cnt_reg <= 4'h0;
		end else if (o_cpu_en || cnt_reg > last) begin
			cnt_reg <= 4'h0;
		end else begin
			cnt_reg <= cnt_reg + 4'h1;
		end
	end
endmodule

`default_nettype wire

// File: logic/wib_sync.v
`default_nettype none

// Two-flop synchroniser for the inbound bus lines.
module wib_sync #(
	parameter W = 16
) (
	// Clock
	input wire i_mclk,
	// Data
	input wire [W-1:0] i_d,
	output wire [W-1:0] o_q
);
	reg [W-1:0] s1_reg;
	reg [W-1:0] s2_reg;

	always @(posedge i_mclk) begin
		s1_reg <= i_d;
		s2_reg <= s1_reg;
	end
	assign o_q = s2_reg;
endmodule

`default_nettype wire

// File: logic/wib_bus.v
// Function
// - With wide enable set, every external move runs as a 16-bit transfer.
// - Low port muxes low address then low data; high port high address then, on wide moves only, data.
// - Wide write drives accumulator on bits 7..0, holding register on 15..8.
// - Wide read returns bits 7..0 to accumulator, 15..8 into holding register.
// - Each wide bus cycle lasts 6 CPU periods (72 or 36 oscillator periods), 18 CPU periods with the stretch bit set.
// - Stretch bit widens read and write strobes from 3 to 15 CPU periods.
// - Short-pointer moves drive the port register on the high port.
// - With pointer-high disable set, pointer moves drive the port register high.
// - Address latch strobe marks valid low address on the low lines.
// - Holding register resets to zero and is software readable and writable.
//
// Local design decision: the APB interface to the registers.
`include "wib_map.vh"
`default_nettype none

module wib_bus (
	// Clock and reset
	input wire i_mclk,
	input wire i_rst_n,
	// APB slave
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [9:0] i_paddr,
	input wire [31:0] i_pwdata,
	output wire o_pready,
	output wire o_pslverr,
	output reg [31:0] o_prdata,
	// Low port lines
	input wire [7:0] i_low_port,
	output reg [7:0] o_low_port,
	output reg o_low_port_oe,
	// High port lines
	input wire [7:0] i_high_port,
	output reg [7:0] o_high_port,
	output reg o_high_port_oe,
	// Strobes, active low except the latch strobe
	output reg o_ale,
	output reg o_rd_n,
	output reg o_wr_n
);
	// ****************************************************************
	// Registers and state
	// ****************************************************************
	localparam ST_IDLE = 2'd0;
	localparam ST_ADDR = 2'd1;
	localparam ST_STROBE = 2'd2;
	localparam ST_TAIL = 2'd3;

	reg [7:0] hold_reg;
	reg [3:0] ctrl_reg;
	reg [15:0] ptr_reg;
	reg [7:0] sfrp_reg;
	reg [7:0] acc_reg;
	reg busy_reg;
	reg is_read_reg;
	reg is_short_reg;
	reg is_wide_reg;
	reg [1:0] st_reg;
	reg [3:0] cnt_reg;
	reg ale_arm_reg;
	wire cpu_en;
	wire [15:0] pins_s;
	wire wr_acc;
	wire rd_acc;
	wire go;
	wire [3:0] strobe_len;
	wire [7:0] high_addr;

	// Cycle enable from the oscillator divider.
	wib_cpu_clk u_clk (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_double_speed_mode(ctrl_reg[`WIB_CTRL_X2]),
		.o_cpu_en(cpu_en)
	);

	// Port lines come from off chip and are resynchronised before use.
	wib_sync #(.W(16)) u_sync (
		.i_mclk(i_mclk),
		.i_d({i_high_port, i_low_port}),
		.o_q(pins_s)
	);

	// ****************************************************************
	// APB slave
	// ****************************************************************
	// Zero wait states: every access completes in its first access cycle.
	assign o_pready = 1'b1;
	assign o_pslverr = 1'b0;
	assign wr_acc = i_psel && i_penable && i_pwrite;
	assign rd_acc = i_psel && !i_penable && !i_pwrite;
	// A command write while a move is running is dropped; software polls busy.
	assign go = wr_acc && (i_paddr == `WIB_ADDR_CMD) && i_pwdata[`WIB_CMD_GO] && !busy_reg;

	function [31:0] rd_mux;
		input [9:0] a;
		begin
			case (a)
				`WIB_ADDR_HOLD: rd_mux = {24'h000000, hold_reg};
				`WIB_ADDR_CTRL: rd_mux = {28'h0000000, ctrl_reg};
				`WIB_ADDR_STAT: rd_mux = {31'h00000000, busy_reg};
				`WIB_ADDR_PTR: rd_mux = {16'h0000, ptr_reg};
				`WIB_ADDR_SFRP: rd_mux = {24'h000000, sfrp_reg};
				`WIB_ADDR_ACC: rd_mux = {24'h000000, acc_reg};
				default: rd_mux = 32'h00000000;
			endcase
		end
	endfunction

	// Read data is registered in the setup cycle so it is stable in the access cycle.
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_prdata <= 32'h00000000;
		end else if (rd_acc) begin
			o_prdata <= rd_mux(i_paddr);
		end
	end

	// ****************************************************************
	// Software registers
	// ****************************************************************
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			hold_reg <= `WIB_HOLD_RST;
			ctrl_reg <= `WIB_CTRL_RST;
			ptr_reg <= 16'h0000;
			sfrp_reg <= 8'h00;
			acc_reg <= 8'h00;
		end else begin
			if (wr_acc) begin
				case (i_paddr)
					`WIB_ADDR_HOLD: hold_reg <= i_pwdata[7:0];
					`WIB_ADDR_CTRL: ctrl_reg <= i_pwdata[3:0];
					`WIB_ADDR_PTR: ptr_reg <= i_pwdata[15:0];
					`WIB_ADDR_SFRP: sfrp_reg <= i_pwdata[7:0];
					`WIB_ADDR_ACC: acc_reg <= i_pwdata[7:0];
					default: ;
				endcase
			end
			// Hardware capture at the strobe's end outranks a software write.
			if (cpu_en && st_reg == ST_STROBE && cnt_reg == 4'h1 && is_read_reg) begin
				acc_reg <= pins_s[7:0];
				if (is_wide_reg) begin
					hold_reg <= pins_s[15:8];
				end
			end
		end
	end

	// ****************************************************************
	// Bus cycle sequencer
	// ****************************************************************
	assign strobe_len = ctrl_reg[`WIB_CTRL_STRETCH] ? `WIB_STROBE_LONG : `WIB_STROBE_CPU;
	// Short pointer and page mode both put the port register on the high lines.
	assign high_addr = (is_short_reg || ctrl_reg[`WIB_CTRL_PHDIS]) ?
		sfrp_reg : ptr_reg[15:8];

	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			st_reg <= ST_IDLE;
			cnt_reg <= 4'h0;
			busy_reg <= 1'b0;
			is_read_reg <= 1'b0;
			is_short_reg <= 1'b0;
			is_wide_reg <= 1'b0;
		end else begin
			if (go) begin
				busy_reg <= 1'b1;
				is_read_reg <= i_pwdata[`WIB_CMD_READ];
				is_short_reg <= i_pwdata[`WIB_CMD_SHORT];
				is_wide_reg <= ctrl_reg[`WIB_CTRL_WIDE];
			end
			if (cpu_en) begin
				case (st_reg)
					ST_IDLE: begin
						if (busy_reg) begin
							st_reg <= ST_ADDR;
							cnt_reg <= 4'h2;
						end
					end
					// Two address periods, strobe, one tail period: 2+3+1 = 6, or 2+15+1 = 18 with the stretch bit set.
					ST_ADDR: begin
						if (cnt_reg == 4'h1) begin
							st_reg <= ST_STROBE;
							cnt_reg <= strobe_len;
						end else begin
							cnt_reg <= cnt_reg - 4'h1;
						end
					end
					ST_STROBE: begin
						if (cnt_reg == 4'h1) begin
							st_reg <= ST_TAIL;
						end else begin
							cnt_reg <= cnt_reg - 4'h1;
						end
					end
					ST_TAIL: begin
						st_reg <= ST_IDLE;
						busy_reg <= 1'b0;
					end
					default: st_reg <= ST_IDLE;
				endcase
			end
		end
	end

	// ****************************************************************
	// Pin drivers
	// ****************************************************************
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_ale <= 1'b0;
			ale_arm_reg <= 1'b0;
			o_rd_n <= 1'b1;
			o_wr_n <= 1'b1;
			o_low_port <= 8'h00;
			o_low_port_oe <= 1'b0;
			o_high_port <= 8'h00;
			o_high_port_oe <= 1'b0;
		end else begin
			// The latch strobe lasts one clock, in the first clock the address is driven.
			ale_arm_reg <= cpu_en && (st_reg == ST_IDLE) && busy_reg;
			o_ale <= ale_arm_reg;
			o_rd_n <= !((st_reg == ST_STROBE) && is_read_reg);
			o_wr_n <= !((st_reg == ST_STROBE) && !is_read_reg);
			case (st_reg)
				ST_ADDR: begin
					o_low_port <= ptr_reg[7:0];
					o_low_port_oe <= 1'b1;
					o_high_port <= high_addr;
					o_high_port_oe <= 1'b1;
				end
				ST_STROBE, ST_TAIL: begin
					o_low_port <= acc_reg;
					o_low_port_oe <= !is_read_reg;
					// Narrow moves keep the address on the high lines.
					o_high_port <= is_wide_reg ? hold_reg : high_addr;
					o_high_port_oe <= !(is_read_reg && is_wide_reg);
				end
				default: begin
					o_low_port_oe <= 1'b0;
					o_high_port_oe <= 1'b0;
				end
			endcase
		end
	end
endmodule

`default_nettype wire

// File: bench/wib_bus_asserts.sv
`default_nettype none
module wib_bus_chk (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// Bus pins
	input wire logic o_ale,
	input wire logic o_rd_n,
	input wire logic o_wr_n,
	input wire logic o_low_port_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	property p_ale_pulse; $rose(o_ale) |=> !o_ale; endproperty
	a_ale_pulse: assert property (p_ale_pulse) else $error("ale too wide");
	property p_ale_addr; o_ale |-> o_low_port_oe; endproperty
	a_ale_addr: assert property (p_ale_addr) else $error("ale without address");
	property p_wr_drive; !o_wr_n |-> o_low_port_oe; endproperty
	a_wr_drive: assert property (p_wr_drive) else $error("write data not driven");
	property p_rd_free; !o_rd_n |-> !o_low_port_oe; endproperty
	a_rd_free: assert property (p_rd_free) else $error("low port driven in read");
	property p_rd_min; $fell(o_rd_n) |=> !o_rd_n [*8]; endproperty
	a_rd_min: assert property (p_rd_min) else $error("read strobe short");
	property p_wr_min; $fell(o_wr_n) |=> !o_wr_n [*8]; endproperty
	a_wr_min: assert property (p_wr_min) else $error("write strobe short");
	property p_wr_max; $fell(o_wr_n) |-> ##[1:200] o_wr_n; endproperty
	a_wr_max: assert property (p_wr_max) else $error("write strobe stuck");
	property p_addr_first; $rose(o_ale) |-> ##[1:60] (!o_rd_n || !o_wr_n); endproperty
	a_addr_first: assert property (p_addr_first) else $error("no strobe after ale");
endmodule
bind wib_bus wib_bus_chk u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .o_ale(o_ale),
	.o_rd_n(o_rd_n), .o_wr_n(o_wr_n), .o_low_port_oe(o_low_port_oe));
`default_nettype wire

// File: bench/wib_disk_model.sv
`default_nettype none
module wib_disk_model (
	// Pins from the block
	input wire logic i_mclk,
	input wire logic i_ale,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic [7:0] i_lo,
	input wire logic [7:0] i_hi,
	input wire logic [15:0] i_rdata,
	// Lines back and observations
	output logic [7:0] o_lo,
	output logic [7:0] o_hi,
	output logic [15:0] o_addr,
	output logic [15:0] o_wdata,
	output int o_width
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	initial {o_hi, o_lo} = 16'h0000;
	always @(posedge i_mclk) begin
		if (i_ale)
			o_addr <= {i_hi, i_lo};
		cnt <= (i_rd_n && i_wr_n) ? 0 : cnt + 1;
		if (!i_rd_n || !i_wr_n)
			o_width <= cnt + 1;
		if (!i_wr_n)
			o_wdata <= {i_hi, i_lo};
		// Released lines toggle so stale data can never look valid.
		{o_hi, o_lo} <= i_rd_n ? ~{o_hi, o_lo} : i_rdata;
	end
endmodule
`default_nettype wire

// File: bench/tb.sv
`include "wib_map.vh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [9:0] paddr = 10'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdata;
	logic [15:0] dev_data = 16'h0, addr, wdata;
	logic pready, lo_oe, hi_oe, ale, rd_n, wr_n;
	logic [7:0] lo_out, hi_out, lo_m, hi_m;
	wire logic [7:0] lo_in = lo_oe ? lo_out : lo_m;
	wire logic [7:0] hi_in = hi_oe ? hi_out : hi_m;
	int width, n_errors = 0, n_checks = 0, cyc = 0;
	always #25 mclk = ~mclk;
	wib_bus uut (.i_mclk(mclk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
		.o_pslverr(), .o_prdata(prdata), .i_low_port(lo_in), .o_low_port(lo_out),
		.o_low_port_oe(lo_oe), .i_high_port(hi_in), .o_high_port(hi_out),
		.o_high_port_oe(hi_oe), .o_ale(ale), .o_rd_n(rd_n), .o_wr_n(wr_n));
	wib_disk_model dev (.i_mclk(mclk), .i_ale(ale), .i_rd_n(rd_n), .i_wr_n(wr_n),
		.i_lo(lo_in), .i_hi(hi_in), .i_rdata(dev_data), .o_lo(lo_m), .o_hi(hi_m),
		.o_addr(addr), .o_wdata(wdata), .o_width(width));
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		do @(posedge mclk); while (pready !== 1'b1);
		rdata = prdata;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic mv(input logic [31:0] c);
		apb(1, `WIB_ADDR_CMD, c);
		do apb(0, `WIB_ADDR_STAT, 0); while (rdata[0] !== 1'b0);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// The ceiling, 20000 clocks, is over eighty times the longest stretched sequence (18 CPU periods of 12 clocks).
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			end_of_test();
		end
	end
	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1;
		apb(0, `WIB_ADDR_HOLD, 0);
		chk(rdata, 32'h0);
		apb(1, `WIB_ADDR_HOLD, 32'ha5);
		apb(0, `WIB_ADDR_HOLD, 0);
		chk(rdata, 32'ha5);
		apb(0, 10'h010, 0);
		chk(rdata, 32'h0);
		$display("test 1 done");
		apb(1, `WIB_ADDR_CTRL, 32'h1);
		apb(1, `WIB_ADDR_PTR, 32'h1234);
		apb(1, `WIB_ADDR_SFRP, 32'h77);
		apb(1, `WIB_ADDR_ACC, 32'h5a);
		apb(1, `WIB_ADDR_HOLD, 32'hc3);
		mv(32'h1);
		chk(addr, 16'h1234);
		chk(wdata, 16'hc35a);
		chk(width, 36);
		dev_data <= 16'hbeef;
		mv(32'h3);
		apb(0, `WIB_ADDR_ACC, 0);
		chk(rdata, 32'hef);
		apb(0, `WIB_ADDR_HOLD, 0);
		chk(rdata, 32'hbe);
		mv(32'h5);
		chk(addr[15:8], 8'h77);
		$display("test 2 done");
		apb(1, `WIB_ADDR_CTRL, 32'h5);
		mv(32'h1);
		chk(addr, 16'h7734);
		apb(1, `WIB_ADDR_CTRL, 32'h0);
		dev_data <= 16'h1122;
		mv(32'h3);
		apb(0, `WIB_ADDR_ACC, 0);
		chk(rdata, 32'h22);
		apb(0, `WIB_ADDR_HOLD, 0);
		chk(rdata, 32'hbe);
		$display("test 3 done");
		apb(1, `WIB_ADDR_CTRL, 32'hb);
		mv(32'h3);
		chk(width, 90);
		apb(1, `WIB_ADDR_CTRL, 32'h9);
		mv(32'h1);
		chk(width, 18);
		$display("test 4 done");
		end_of_test();
	end
endmodule
`default_nettype wire
